// ==== rtl/term_io.v ====
// drive terminal io conditioning: six inputs through polarity, filter and delays,
// input function decode, and function selection for four digital outputs.
// assumes APB master on MCLK, terminal pins asynchronous, drive status on MCLK.
`timescale 1ns/100ps
`default_nettype none
`include "term_io_defs.vh"
module term_io
(
   input  wire        MCLK,
   input  wire        RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire [5:0]  TERM_IN,
   input  wire        FAULT_ACTIVE,
   input  wire        RUNNING,
   input  wire        REVERSE,
   input  wire        JOGGING,
   input  wire        FREQ_NONZERO,
   input  wire        REF_NONZERO,
   input  wire        FREQ_LEVEL_FIRST,
   input  wire        FREQ_LEVEL_SECOND,
   input  wire        FREQ_REACHED,
   input  wire        FAST_PULSE_TRAIN,
   output wire [5:0]  INPUT_STATE,
   output wire [1:0]  RUN_MODE,
   output wire [1:0]  FAST_INPUT_DIGITAL,
   output wire        ENC_CLEAR,
   output wire        PULSE_UP,
   output wire        PULSE_DOWN,
   output wire        PULSE_SUPERIMPOSE,
   output wire        GEAR_SELECT,
   output wire        REQ_VF,
   output wire        REQ_VECTOR,
   output wire        PID_INVERT,
   output wire        RELAY_ONE,
   output wire        RELAY_TWO,
   output wire        OPEN_COLLECTOR,
   output wire        FAST_OUT,
   output wire        FAST_OUT_PULSE_MODE
);

   localparam TICK_W = 17;
   localparam integer TICK_LAST_INT = `TICK_CYCLES - 1;
   localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_INT[TICK_W-1:0];
   // configuration
   reg  [5:0]  polarity_reg;
   reg  [15:0] filter_ms_reg;
   reg  [8:0]  virt_en_reg;
   reg  [5:0]  virt_val_reg;
   reg  [1:0]  run_mode_reg;
   reg  [7:0]  fast_type_reg;
   reg         hs_mode_reg;
   reg  [6:0]  in_func_reg   [0:5];
   reg  [5:0]  out_func_reg  [0:3];
   reg  [15:0] on_delay_reg  [0:5];
   reg  [15:0] off_delay_reg [0:5];
   // state
   reg  [TICK_W-1:0] tick_cnt_reg;
   reg         tick_reg;
   reg  [5:0]  sync1_reg;
   reg  [5:0]  sync2_reg;
   reg  [5:0]  filt_reg;
   reg  [15:0] filt_cnt_reg [0:5];
   reg  [5:0]  state_reg;
   reg  [5:0]  state_d_reg;
   reg  [15:0] dly_cnt_reg  [0:5];
   reg  [5:0]  snap_reg;
   reg         fault_d_reg;
   reg  [3:0]  out_reg;
   reg  [31:0] rdata_reg;
   reg  [8:0]  fn_hit;
   reg  [8:0]  fn_rise;
   reg  [5:0]  virt_sel;
   wire [5:0]  raw_level;
   wire        wr_en;
   wire        zero_speed;
   // saturate a written time to its allowed maximum
   function [15:0] clamp_ms;
      input [31:0] val;
      input [15:0] lim;
      begin
         clamp_ms = (val[31:16] != 16'h0000 || val[15:0] > lim) ? lim : val[15:0];
      end
   endfunction
   // output function decode shared by all four outputs
   function out_level;
      input [5:0] fn;
      input       zs;
      begin
         case (fn)
            `OUT_FN_NONE:     out_level = 1'b0;
            `OUT_FN_RUN:      out_level = RUNNING & FREQ_NONZERO;
            `OUT_FN_FWD:      out_level = RUNNING & FREQ_NONZERO & ~REVERSE;
            `OUT_FN_REV:      out_level = RUNNING & FREQ_NONZERO & REVERSE;
            `OUT_FN_JOG:      out_level = JOGGING & FREQ_NONZERO;
            `OUT_FN_FAULT:    out_level = FAULT_ACTIVE;
            `OUT_FN_FREQ_LEVEL_DETECTOR_FIRST:     out_level = FREQ_LEVEL_FIRST;
            `OUT_FN_FREQ_LEVEL_DETECTOR_SECOND:     out_level = FREQ_LEVEL_SECOND;
            `OUT_FN_REACHED:  out_level = FREQ_REACHED;
            `OUT_FN_ZERO_SPD: out_level = zs;
            default:          out_level = 1'b0;
         endcase
      end
   endfunction
   assign wr_en = PSEL & PENABLE & PWRITE;
   // APB register writes; times saturate rather than wrap
   always @(posedge MCLK)
   begin : reg_write
      integer i;
      if (RST)
      begin
         polarity_reg  <= `POLARITY_RST;
         filter_ms_reg <= `FILTER_RST_MS;
         virt_en_reg   <= `VIRT_EN_RST;
         virt_val_reg  <= 6'h00;
         run_mode_reg  <= `RUN_MODE_RST;
         fast_type_reg <= `FAST_TYPE_RST;
         hs_mode_reg   <= 1'b0;
         for (i = 0; i < 6; i = i + 1)
         begin
            in_func_reg[i]   <= 7'd0;
            on_delay_reg[i]  <= `DELAY_RST_MS;
            off_delay_reg[i] <= `DELAY_RST_MS;
         end
         for (i = 0; i < 4; i = i + 1)
            out_func_reg[i] <= `OUT_FN_NONE;
      end
      else if (wr_en)
      begin
         case (PADDR)
            `OFF_POLARITY:  polarity_reg  <= PWDATA[5:0];
            `OFF_FILTER:    filter_ms_reg <= clamp_ms(PWDATA, `FILTER_MAX_MS);
            `OFF_VIRT_EN:   virt_en_reg   <= PWDATA[8:0];
            `OFF_RUN_MODE:  run_mode_reg  <= PWDATA[1:0];
            `OFF_FAST_TYPE: fast_type_reg <= {3'b000, PWDATA[4], 3'b000, PWDATA[0]};
            `OFF_VIRT_VAL:  virt_val_reg  <= PWDATA[5:0];
            `OFF_HS_MODE:   hs_mode_reg   <= PWDATA[0];
            default:
            begin
               for (i = 0; i < 6; i = i + 1)
               begin
                  if (PADDR == `OFF_IN_FUNC0 + 4 * i)
                     in_func_reg[i] <= PWDATA[6:0];
                  if (PADDR == `OFF_ON_DELAY0 + 4 * i)
                     on_delay_reg[i] <= clamp_ms(PWDATA, `DELAY_MAX_MS);
                  if (PADDR == `OFF_OFF_DELAY0 + 4 * i)
                     off_delay_reg[i] <= clamp_ms(PWDATA, `DELAY_MAX_MS);
               end
               for (i = 0; i < 4; i = i + 1)
                  if (PADDR == `OFF_OUT_FUNC0 + 4 * i)
                     out_func_reg[i] <= PWDATA[5:0];
            end
         endcase
      end
   end
   // one millisecond timebase
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         tick_cnt_reg <= {TICK_W{1'b0}};
         tick_reg     <= 1'b0;
      end
      else if (tick_cnt_reg == TICK_LAST)
      begin
         tick_cnt_reg <= {TICK_W{1'b0}};
         tick_reg     <= 1'b1;
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
         tick_reg     <= 1'b0;
      end
   end
   // virtual mask has a hole: the second fast input sits at bit 8
   always @*
   begin
      virt_sel = {virt_en_reg[`VIRT_BIT_FAST_SECOND], virt_en_reg[`VIRT_BIT_FAST_FIRST:0]};
   end
   // pins are asynchronous: two flops before anything looks at them
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end
      else
      begin
         sync1_reg <= TERM_IN;
         sync2_reg <= sync1_reg;
      end
   end
   // virtual source replaces the pin, then polarity picks the active level
   assign raw_level = ((sync2_reg & ~virt_sel) | (virt_val_reg & virt_sel)) ^ polarity_reg;
   // filter: a new level passes only after it stayed put for the filter time
   always @(posedge MCLK)
   begin : filt_update
      integer i;
      if (RST)
      begin
         filt_reg <= 6'h00;
         for (i = 0; i < 6; i = i + 1)
            filt_cnt_reg[i] <= 16'd0;
      end
      else
      begin
         for (i = 0; i < 6; i = i + 1)
         begin
            if (raw_level[i] == filt_reg[i])
               filt_cnt_reg[i] <= 16'd0;
            else if (filt_cnt_reg[i] >= filter_ms_reg)
            begin
               filt_reg[i]     <= raw_level[i];
               filt_cnt_reg[i] <= 16'd0;
            end
            else if (tick_reg)
               filt_cnt_reg[i] <= filt_cnt_reg[i] + 16'd1;
         end
      end
   end
   // switch-on and switch-off delays after the filter; a bounce restarts the wait
   always @(posedge MCLK)
   begin : delay_update
      integer i;
      if (RST)
      begin
         state_reg <= 6'h00;
         for (i = 0; i < 6; i = i + 1)
            dly_cnt_reg[i] <= 16'd0;
      end
      else
      begin
         for (i = 0; i < 6; i = i + 1)
         begin
            if (filt_reg[i] == state_reg[i])
               dly_cnt_reg[i] <= 16'd0;
            else if (filt_reg[i] && dly_cnt_reg[i] >= on_delay_reg[i])
            begin
               state_reg[i]   <= 1'b1;
               dly_cnt_reg[i] <= 16'd0;
            end
            else if (!filt_reg[i] && dly_cnt_reg[i] >= off_delay_reg[i])
            begin
               state_reg[i]   <= 1'b0;
               dly_cnt_reg[i] <= 16'd0;
            end
            else if (tick_reg)
               dly_cnt_reg[i] <= dly_cnt_reg[i] + 16'd1;
         end
      end
   end
   // fault snapshot taken on the rising edge of the fault indication
   always @(posedge MCLK)
   begin
      if (RST)
      begin
         snap_reg    <= 6'h00;
         fault_d_reg <= 1'b0;
         state_d_reg <= 6'h00;
      end
      else
      begin
         fault_d_reg <= FAULT_ACTIVE;
         state_d_reg <= state_reg;
         if (FAULT_ACTIVE && !fault_d_reg)
            snap_reg <= state_reg;
      end
   end
   // input function decode: index 0..7 for codes 59,60,61,66..70
   always @*
   begin : fn_decode
      integer i;
      fn_hit  = 9'h000;
      fn_rise = 9'h000;
      i       = 0;
      for (i = 0; i < 6; i = i + 1)
      begin
         case (in_func_reg[i])
            `IN_FN_VF:        fn_hit[0] = fn_hit[0] | state_reg[i];
            `IN_FN_VECTOR:    fn_hit[1] = fn_hit[1] | state_reg[i];
            `IN_FN_PID_INV:   fn_hit[2] = fn_hit[2] | state_reg[i];
            `IN_FN_ENC_CLR:   fn_rise[3] = fn_rise[3] | (state_reg[i] & ~state_d_reg[i]);
            `IN_FN_PULSE_UP:  fn_rise[4] = fn_rise[4] | (state_reg[i] & ~state_d_reg[i]);
            `IN_FN_PULSE_SUP: fn_hit[5] = fn_hit[5] | state_reg[i];
            `IN_FN_PULSE_DN:  fn_rise[6] = fn_rise[6] | (state_reg[i] & ~state_d_reg[i]);
            `IN_FN_GEAR:      fn_hit[7] = fn_hit[7] | state_reg[i];
            default:          fn_hit[8] = fn_hit[8];
         endcase
      end
   end

   // zero speed: running with output and reference both at zero
   assign zero_speed = RUNNING & ~FREQ_NONZERO & ~REF_NONZERO;

   // output function selection, registered so outputs are glitch free
   always @(posedge MCLK)
   begin : out_select
      integer i;
      if (RST)
         out_reg <= 4'h0;
      else
         for (i = 0; i < 4; i = i + 1)
            out_reg[i] <= out_level(out_func_reg[i], zero_speed);
   end

   // read mux; unmapped addresses read zero
   always @*
   begin : read_mux
      integer i;
      rdata_reg = 32'h00000000;
      i         = 0;
      case (PADDR)
         `OFF_POLARITY:   rdata_reg = {26'h0, polarity_reg};
         `OFF_FILTER:     rdata_reg = {16'h0, filter_ms_reg};
         `OFF_VIRT_EN:    rdata_reg = {23'h0, virt_en_reg};
         `OFF_RUN_MODE:   rdata_reg = {30'h0, run_mode_reg};
         `OFF_FAST_TYPE:  rdata_reg = {24'h0, fast_type_reg};
         `OFF_VIRT_VAL:   rdata_reg = {26'h0, virt_val_reg};
         `OFF_LIVE_STATE: rdata_reg = {26'h0, state_reg};
         `OFF_FAULT_SNAP: rdata_reg = {26'h0, snap_reg};
         `OFF_HS_MODE:    rdata_reg = {31'h0, hs_mode_reg};
         `OFF_EVENTS:     rdata_reg = {23'h0, fn_hit};
         default:
         begin
            for (i = 0; i < 6; i = i + 1)
            begin
               if (PADDR == `OFF_IN_FUNC0 + 4 * i)
                  rdata_reg = {25'h0, in_func_reg[i]};
               if (PADDR == `OFF_ON_DELAY0 + 4 * i)
                  rdata_reg = {16'h0, on_delay_reg[i]};
               if (PADDR == `OFF_OFF_DELAY0 + 4 * i)
                  rdata_reg = {16'h0, off_delay_reg[i]};
            end
            for (i = 0; i < 4; i = i + 1)
               if (PADDR == `OFF_OUT_FUNC0 + 4 * i)
                  rdata_reg = {26'h0, out_func_reg[i]};
         end
      endcase
   end

   assign PRDATA  = rdata_reg;
   assign PREADY  = 1'b1;      // zero wait states
   assign PSLVERR = 1'b0;

   assign INPUT_STATE         = state_reg;
   assign RUN_MODE            = run_mode_reg;
   assign FAST_INPUT_DIGITAL  = {fast_type_reg[4], fast_type_reg[0]};
   assign ENC_CLEAR           = fn_rise[3];
   assign PULSE_UP            = fn_rise[4];
   assign PULSE_DOWN          = fn_rise[6];
   assign PULSE_SUPERIMPOSE   = fn_hit[5];
   assign GEAR_SELECT         = fn_hit[7];
   assign REQ_VF              = fn_hit[0];
   assign REQ_VECTOR          = fn_hit[1];
   assign PID_INVERT          = fn_hit[2];
   assign RELAY_ONE           = out_reg[0];
   assign RELAY_TWO           = out_reg[1];
   assign OPEN_COLLECTOR      = out_reg[2];
   // pulse mode hands the pin to the pulse generator outside
   assign FAST_OUT            = hs_mode_reg ? out_reg[3] : FAST_PULSE_TRAIN;
   assign FAST_OUT_PULSE_MODE = ~hs_mode_reg;

endmodule
`default_nettype wire

// ==== rtl/term_io_defs.vh ====
// constants for the drive terminal input conditioning and output function block
// assumes a 125 MHz system clock and an APB register bus with byte addresses
`ifndef TERM_IO_DEFS_VH
`define TERM_IO_DEFS_VH
// timebase
`define CLK_FREQ_KHZ        125000
`define TICK_PERIOD_MS      1
`define TICK_CYCLES         (`CLK_FREQ_KHZ * `TICK_PERIOD_MS)
// time limits in milliseconds
`define FILTER_MAX_MS       16'd1000
`define FILTER_RST_MS       16'd10
`define DELAY_MAX_MS        16'd50000
`define DELAY_RST_MS        16'd0
// register byte offsets
`define OFF_POLARITY        12'h000
`define OFF_FILTER          12'h004
`define OFF_VIRT_EN         12'h008
`define OFF_RUN_MODE        12'h00C
`define OFF_FAST_TYPE       12'h010
`define OFF_VIRT_VAL        12'h014
`define OFF_LIVE_STATE      12'h018
`define OFF_FAULT_SNAP      12'h01C
`define OFF_IN_FUNC0        12'h020
`define OFF_OUT_FUNC0       12'h040
`define OFF_ON_DELAY0       12'h080
`define OFF_OFF_DELAY0      12'h0A0
`define OFF_HS_MODE         12'h0C0
`define OFF_EVENTS          12'h0C4
// reset values
`define POLARITY_RST        6'h00
`define VIRT_EN_RST         9'h000
`define RUN_MODE_RST        2'h0
`define FAST_TYPE_RST       8'h00
// virtual mask bit positions
`define VIRT_BIT_FAST_FIRST  4
`define VIRT_BIT_FAST_SECOND 8
// input function codes
`define IN_FN_VF            7'd59
`define IN_FN_VECTOR        7'd60
`define IN_FN_PID_INV       7'd61
`define IN_FN_ENC_CLR       7'd66
`define IN_FN_PULSE_UP      7'd67
`define IN_FN_PULSE_SUP     7'd68
`define IN_FN_PULSE_DN      7'd69
`define IN_FN_GEAR          7'd70
// output function codes
`define OUT_FN_NONE         6'd0
`define OUT_FN_RUN          6'd1
`define OUT_FN_FWD          6'd2
`define OUT_FN_REV          6'd3
`define OUT_FN_JOG          6'd4
`define OUT_FN_FAULT        6'd5
`define OUT_FN_FREQ_LEVEL_DETECTOR_FIRST         6'd6
`define OUT_FN_FREQ_LEVEL_DETECTOR_SECOND         6'd7
`define OUT_FN_REACHED      6'd8
`define OUT_FN_ZERO_SPD     6'd9
`endif

// ==== testbench/term_io_asserts.sv ====
// checker for the terminal io block, bound to its top module
// assumes one clock domain and the register map of term_io_defs.vh
`timescale 1ns/100ps
`default_nettype none
`include "term_io_defs.vh"
module term_io_asserts
(
   input wire logic        MCLK,
   input wire logic        RST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [5:0]  INPUT_STATE,
   input wire logic [1:0]  RUN_MODE,
   input wire logic [1:0]  FAST_INPUT_DIGITAL,
   input wire logic        ENC_CLEAR,
   input wire logic        FAST_PULSE_TRAIN,
   input wire logic        FAST_OUT,
   input wire logic        FAST_OUT_PULSE_MODE
);
   // write fields sliced here, since the properties look back at them
   wire logic [1:0] wr_mode = PWDATA[1:0];
   wire logic [1:0] wr_fast = {PWDATA[4], PWDATA[0]};
   wire logic       wr_hit  = PSEL & PENABLE & PWRITE;
   wire logic       rd_sel  = PSEL & ~PWRITE;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   pready_a: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access phase without ready");
   no_error_a: assert property (PSEL && PENABLE |-> !PSLVERR)
      else $error("error response seen");
   live_read_a: assert property (rd_sel && PADDR == `OFF_LIVE_STATE |-> PRDATA == {26'h0, INPUT_STATE})
      else $error("live state read differs from input state");
   run_mode_a: assert property (wr_hit && PADDR == `OFF_RUN_MODE |=> RUN_MODE == $past(wr_mode))
      else $error("run mode not taken from write");
   fast_type_a: assert property (wr_hit && PADDR == `OFF_FAST_TYPE |=> FAST_INPUT_DIGITAL == $past(wr_fast))
      else $error("fast input type not taken from write");
   unmapped_a: assert property (rd_sel && PADDR == 12'h0FC |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   enc_pulse_a: assert property (ENC_CLEAR |=> !ENC_CLEAR)
      else $error("encoder clear longer than one cycle");
   pulse_pass_a: assert property (FAST_OUT_PULSE_MODE |-> FAST_OUT == FAST_PULSE_TRAIN)
      else $error("pulse train not passed to fast output");
endmodule
bind term_io term_io_asserts term_io_asserts_i
(
   .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .INPUT_STATE(INPUT_STATE),
   .RUN_MODE(RUN_MODE), .FAST_INPUT_DIGITAL(FAST_INPUT_DIGITAL), .ENC_CLEAR(ENC_CLEAR),
   .FAST_PULSE_TRAIN(FAST_PULSE_TRAIN), .FAST_OUT(FAST_OUT), .FAST_OUT_PULSE_MODE(FAST_OUT_PULSE_MODE)
);
`default_nettype wire

// ==== testbench/field_contacts.sv ====
// field contact model driving the six terminal pins
// assumes the bench changes level_cmd and lag just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module field_contacts
(
   input  wire logic       clk,
   input  wire logic [5:0] level_cmd,
   input  wire logic [3:0] lag,
   output var  logic [5:0] pins
);
   logic [5:0] target = 6'h00;
   logic [3:0] wait_cnt = 4'h0;
   initial pins = 6'h00;
   // a new command restarts the settle count, so a slow contact closes late
   always @(posedge clk)
   begin
      if (level_cmd != target)
      begin
         target <= level_cmd;
         wait_cnt <= lag;
      end
      else if (wait_cnt != 4'h0)
         wait_cnt <= wait_cnt - 4'h1;
      else
         pins <= target;
   end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the terminal io block
// assumes 125 MHz clock; ms timing only probed as "not yet", since a tick is 125000 cycles
`timescale 1ns/100ps
`default_nettype none
`include "term_io_defs.vh"
module testbench;
   logic        mclk, rst, psel, penable, pwrite, pulse_train, e, pulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [8:0]  st;
   logic [5:0]  cmd;
   logic [3:0]  lag;
   wire  logic [31:0] prdata;
   wire  logic        pready, pslverr, r1, r2, oc, fout, fpm;
   wire  logic [7:0]  fo;
   wire  logic [5:0]  pins, state;
   wire  logic [1:0]  run_mode, fast_dig;
   int          failures = 0, n_checks = 0, cyc = 0, hits;
   logic [11:0] rst_addr [9] = '{`OFF_POLARITY, `OFF_FILTER, `OFF_VIRT_EN, `OFF_RUN_MODE, `OFF_FAST_TYPE,
                                 `OFF_ON_DELAY0, `OFF_OFF_DELAY0, `OFF_LIVE_STATE, `OFF_FAULT_SNAP};
   logic [6:0]  in_codes [8] = '{`IN_FN_VF, `IN_FN_VECTOR, `IN_FN_PID_INV, `IN_FN_ENC_CLR, `IN_FN_PULSE_UP,
                                 `IN_FN_PULSE_SUP, `IN_FN_PULSE_DN, `IN_FN_GEAR};
   logic [8:0]  pats [8] = '{9'h000, 9'h012, 9'h016, 9'h01A, 9'h002, 9'h022, 9'h041, 9'h180};
   logic [7:0]  fast_tab [4] = '{8'h01, 8'h10, 8'h11, 8'h00};

   term_io term_io_i
   (
      .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TERM_IN(pins),
      .FAULT_ACTIVE(st[0]), .RUNNING(st[1]), .REVERSE(st[2]), .JOGGING(st[3]), .FREQ_NONZERO(st[4]),
      .REF_NONZERO(st[5]), .FREQ_LEVEL_FIRST(st[6]), .FREQ_LEVEL_SECOND(st[7]), .FREQ_REACHED(st[8]),
      .FAST_PULSE_TRAIN(pulse_train), .INPUT_STATE(state), .RUN_MODE(run_mode), .FAST_INPUT_DIGITAL(fast_dig),
      .ENC_CLEAR(fo[3]), .PULSE_UP(fo[4]), .PULSE_DOWN(fo[6]), .PULSE_SUPERIMPOSE(fo[5]), .GEAR_SELECT(fo[7]),
      .REQ_VF(fo[0]), .REQ_VECTOR(fo[1]), .PID_INVERT(fo[2]), .RELAY_ONE(r1), .RELAY_TWO(r2),
      .OPEN_COLLECTOR(oc), .FAST_OUT(fout), .FAST_OUT_PULSE_MODE(fpm)
   );
   field_contacts field_contacts_i (.clk(mclk), .level_cmd(cmd), .lag(lag), .pins(pins));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask

   // bounded wait for the conditioned state, then compare
   task automatic wait_state(input logic [5:0] exp);
      int n;
      n = 0;
      while (state !== exp && n < 40)
      begin
         @(posedge mclk);
         n++;
      end
      chk("input state", {26'h0, exp}, {26'h0, state});
   endtask

   // expected output level; s = fault,run,rev,jog,fnz,rnz,lvl1,lvl2,reached
   function automatic logic exp_out(input logic [5:0] c, input logic [8:0] s);
      case (c)
         6'h1: return s[1] & s[4];
         6'h2: return s[1] & ~s[2] & s[4];
         6'h3: return s[1] & s[2] & s[4];
         6'h4: return s[3] & s[4];
         6'h5: return s[0];
         6'h6: return s[6];
         6'h7: return s[7];
         6'h8: return s[8];
         6'h9: return s[1] & ~s[4] & ~s[5];
         default: return 1'b0;
      endcase
   endfunction

   // hang guard; the whole sequence needs well under two thousand cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      st = 9'h000;
      pulse_train = 1'b0;
      cmd = 6'h00;
      lag = 4'h0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++)
         rchk("reset value", rst_addr[i], (i == 1) ? 32'hA : 32'h0);
      chk("pulse mode after reset", 32'h1, {31'h0, fpm});
      // the 10 ms default filter must hold a new level back far beyond 200 cycles
      cmd <= 6'h3F;
      repeat (200) @(posedge mclk);
      chk("filtered state", 32'h0, {26'h0, state});
      apb(1'b1, `OFF_FILTER, 32'h7D0);
      rchk("filter limit", `OFF_FILTER, 32'h3E8);
      apb(1'b1, `OFF_FILTER, 32'h0);
      wait_state(6'h3F);
      apb(1'b1, `OFF_POLARITY, 32'h3F);
      wait_state(6'h00);
      lag <= 4'h9;
      cmd <= 6'h15;
      wait_state(6'h2A);
      lag <= 4'h0;
      apb(1'b1, `OFF_POLARITY, 32'h0);
      wait_state(6'h15);
      rchk("live state", `OFF_LIVE_STATE, 32'h15);
      apb(1'b1, `OFF_VIRT_VAL, 32'h2A);
      apb(1'b1, `OFF_VIRT_EN, 32'h100);
      wait_state(6'h35);
      apb(1'b1, `OFF_VIRT_EN, 32'h1F);
      wait_state(6'h0A);
      apb(1'b1, `OFF_VIRT_EN, 32'h0);
      wait_state(6'h15);
      apb(1'b1, `OFF_ON_DELAY0, 32'hEA60);
      rchk("on delay limit", `OFF_ON_DELAY0, 32'hC350);
      apb(1'b1, `OFF_OFF_DELAY0, 32'hEA60);
      rchk("off delay limit", `OFF_OFF_DELAY0, 32'hC350);
      apb(1'b1, `OFF_ON_DELAY0 + 12'h4, 32'h1);
      cmd <= 6'h16;
      repeat (200) @(posedge mclk);
      chk("delayed state", 32'h15, {26'h0, state});
      cmd <= 6'h15;
      apb(1'b1, `OFF_ON_DELAY0, 32'h0);
      apb(1'b1, `OFF_OFF_DELAY0, 32'h0);
      apb(1'b1, `OFF_ON_DELAY0 + 12'h4, 32'h0);
      wait_state(6'h15);
      cmd <= 6'h21;
      wait_state(6'h21);
      st <= 9'h001;
      repeat (3) @(posedge mclk);
      cmd <= 6'h0C;
      wait_state(6'h0C);
      rchk("fault snapshot", `OFF_FAULT_SNAP, 32'h21);
      st <= 9'h000;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, `OFF_RUN_MODE, 32'(m));
         @(posedge mclk);
         chk("run mode", 32'(m), {30'h0, run_mode});
      end
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, `OFF_FAST_TYPE, {24'h0, fast_tab[i]});
         @(posedge mclk);
         chk("fast input type", {30'h0, fast_tab[i][4], fast_tab[i][0]}, {30'h0, fast_dig});
      end
      cmd <= 6'h00;
      wait_state(6'h00);
      // each input function on terminal one; pulse kinds fire once per activation
      for (int k = 0; k < 8; k++)
      begin
         apb(1'b1, `OFF_IN_FUNC0, {25'h0, in_codes[k]});
         cmd <= 6'h01;
         hits = 0;
         repeat (16)
         begin
            @(posedge mclk);
            hits += (fo[k] === 1'b1);
         end
         pulse = (k == 3 || k == 4 || k == 6);
         chk("function output", pulse ? 32'h0 : (32'h1 << k), {24'h0, fo});
         if (pulse)
            chk("function pulses", 32'h1, 32'(hits));
         cmd <= 6'h00;
         wait_state(6'h00);
         chk("function released", 32'h0, {24'h0, fo});
      end
      apb(1'b1, `OFF_IN_FUNC0, 32'h0);
      apb(1'b1, `OFF_HS_MODE, 32'h1);
      @(posedge mclk);
      chk("pulse mode off", 32'h0, {31'h0, fpm});
      // same code on all four outputs, against each of the eight drive status patterns in pats
      for (int c = 0; c < 10; c++)
      begin
         for (int j = 0; j < 4; j++)
            apb(1'b1, `OFF_OUT_FUNC0 + 12'(4 * j), 32'(c));
         for (int p = 0; p < 8; p++)
         begin
            st <= pats[p];
            repeat (3) @(posedge mclk);
            e = exp_out(6'(c), pats[p]);
            chk("output levels", {28'h0, {4{e}}}, {28'h0, r1, r2, oc, fout});
         end
      end
      apb(1'b1, `OFF_HS_MODE, 32'h0);
      for (int t = 0; t < 2; t++)
      begin
         pulse_train <= t[0];
         repeat (2) @(posedge mclk);
         chk("pulse output", 32'(t), {31'h0, fout});
      end
      apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
      rchk("unmapped read", 12'h0FC, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
